// ---- inc/tlft_pkg.sv ----
// Constants, types and register map of the two-level fault timer
// Operation
// [R01] Timer starts advancing once feedback reaches the peak-current-limit level.
// [R02] In short circuit the timer advances four times faster than overload.
// [R03] Timer clears to zero when both overload and short circuit are gone.
// [R04] Moving between short circuit and overload keeps progress, only rate changes.
// [R05] Timer completion stops every drive pulse at once.
// [R06] After a trip, version input selects hiccup restart or permanent latch-off.
// [R07] Overload threshold is four times the offset-reduced current limit.
// [R08] Timer setting programs overload duration; default setting gives 500 ms.
// [R09] Open or grounded setting pin substitutes a known default duration.
// [R10] Start-up with maximum feedback runs short-circuit rate until regulation clears it.
// [R11] Above light load, peak current command is feedback over four, clamped.
// [R12] Counter adds one per tick in overload, four in short circuit, trips at terminal.
package tlft_pkg;

  // Clock and tick timing
  localparam int CLK_FREQ_KHZ = 10000;
  localparam int TICK_TIME_US = 1000;
  localparam int TICK_CYCLES = (TICK_TIME_US * CLK_FREQ_KHZ + 999) / 1000;

  // Analog levels, in millivolts
  localparam logic [15:0] FB_OPEN_LOOP_MV = 16'h1004; // 4100 mV
  localparam logic [15:0] CS_LIMIT_MV = 16'h0320; // 800 mV
  localparam logic [15:0] LIGHT_LOAD_FB_MV = 16'h03E8; // 1000 mV
  localparam int PEAK_RATIO_SHIFT = 2; // Ratio of 4

  // Timer steps and durations, in ms ticks
  localparam logic [15:0] OVL_STEP = 16'h0001;
  localparam logic [15:0] SC_STEP = 16'h0004;
  localparam logic [15:0] OVL_DEFAULT_MS = 16'h01F4; // 500 ms
  localparam logic [15:0] HICCUP_DEFAULT_MS = 16'h03E8; // 1000 ms

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_POWER_OFFSET = 8'h04;
  localparam logic [7:0] REG_TIMER_SET = 8'h08;
  localparam logic [7:0] REG_HICCUP_SET = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_COUNT = 8'h14;
  localparam logic [7:0] REG_PEAK = 8'h18;

  // Field positions and reset values
  localparam int CTRL_ENABLE_BIT = 0;
  localparam logic CTRL_ENABLE_RESET = 1'b1;
  localparam logic [15:0] POWER_OFFSET_RESET = 16'h0000;

  // Edges before the version strap synchroniser holds the pin level
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // Operating mode of the protection
  typedef enum logic [1:0] {
    TLFT_RUN,
    TLFT_HICCUP,
    TLFT_LATCHED
  } tlft_mode_t;

  // Status word as seen by software
  typedef struct packed {
    logic latch_version;
    logic pin_grounded;
    logic pin_open;
    logic latched;
    logic hiccup;
    logic tripped;
    logic short_circuit_condition;
    logic overload_condition;
  } tlft_status_t;

  // Complete state of the timer block
  typedef struct packed {
    logic [2:0] sync_open;
    logic [2:0] sync_gnd;
    logic [2:0] sync_ver;
    logic pin_open;
    logic pin_gnd;
    logic ver_filt;
    logic latch_version;
    logic strap_done;
    logic [1:0] strap_wait;
    logic enable;
    logic [15:0] power_limit_offset;
    logic [15:0] timer_set;
    logic [15:0] hiccup_set;
    logic [15:0] tick_cnt;
    logic [15:0] count;
    logic [15:0] hiccup_cnt;
    tlft_mode_t mode;
    logic tripped;
    logic overload_condition;
    logic short_circuit_condition;
    logic [15:0] peak_mv;
    logic drive;
    logic a_valid;
    logic a_write;
    logic [7:0] a_addr;
    logic rd_wait;
    logic [31:0] rdata;
  } tlft_regs_t;

endpackage : tlft_pkg

// ---- logic/tlft_top.sv ----
// Two-level fault timer with AHB-Lite register slave
//
// Our own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module tlft_top #(
  parameter int TICK_CYCLES = tlft_pkg::TICK_CYCLES,
  parameter logic [15:0] TIMER_OPEN_MS = tlft_pkg::OVL_DEFAULT_MS,
  parameter logic [15:0] TIMER_GND_MS = tlft_pkg::OVL_DEFAULT_MS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [15:0] feedback_level,
  input wire logic pwm_request,
  input wire logic timer_pin_open,
  input wire logic timer_pin_grounded,
  input wire logic latch_version_pin,
  output logic gate_drive,
  output logic fault_tripped,
  output logic [15:0] peak_current_cmd
);

  tlft_pkg::tlft_regs_t r;
  tlft_pkg::tlft_regs_t next_r;

  // Tick period minus one, cast to counter width
  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

  // Accept a new pin level only when the last two stages agree
  function automatic logic sync_filter(input logic [2:0] chain, input logic cur);
    sync_filter = (chain[1] == chain[2]) ? chain[2] : cur;
  endfunction : sync_filter

  // Overload level: offset-reduced current limit times four
  function automatic logic [15:0] ovl_threshold(input logic [15:0] offset);
    logic [15:0] lim;
    lim = (offset >= tlft_pkg::CS_LIMIT_MV) ? 16'h0000 : (tlft_pkg::CS_LIMIT_MV - offset);
    ovl_threshold = 16'(lim << tlft_pkg::PEAK_RATIO_SHIFT);
  endfunction : ovl_threshold

  // Readback word for one register offset
  function automatic logic [31:0] read_word(input tlft_pkg::tlft_regs_t s, input logic [7:0] addr);
    tlft_pkg::tlft_status_t st;
    st.latch_version = s.latch_version;
    st.pin_grounded = s.pin_gnd;
    st.pin_open = s.pin_open;
    st.latched = (s.mode == tlft_pkg::TLFT_LATCHED);
    st.hiccup = (s.mode == tlft_pkg::TLFT_HICCUP);
    st.tripped = s.tripped;
    st.short_circuit_condition = s.short_circuit_condition;
    st.overload_condition = s.overload_condition;
    case (addr)
      tlft_pkg::REG_CTRL: read_word = {31'h00000000, s.enable};
      tlft_pkg::REG_POWER_OFFSET: read_word = {16'h0000, s.power_limit_offset};
      tlft_pkg::REG_TIMER_SET: read_word = {16'h0000, s.timer_set};
      tlft_pkg::REG_HICCUP_SET: read_word = {16'h0000, s.hiccup_set};
      tlft_pkg::REG_STATUS: read_word = {24'h000000, st};
      tlft_pkg::REG_COUNT: read_word = {16'h0000, s.count};
      tlft_pkg::REG_PEAK: read_word = {16'h0000, s.peak_mv};
      default: read_word = 32'h00000000;
    endcase
  endfunction : read_word

  // Combinational working values
  logic addr_take;
  logic ovl_now;
  logic sc_now;
  logic tick;
  logic [15:0] terminal;
  logic [15:0] step;
  logic [16:0] sum;
  logic trip_now;
  logic [15:0] peak_raw;
  logic [15:0] peak_max;

  // Next-state logic for the whole block
  always_comb begin
    next_r = r;
    addr_take = hsel && htrans[1] && hready;
    ovl_now = 1'b0;
    sc_now = 1'b0;
    tick = 1'b0;
    terminal = 16'h0000;
    step = 16'h0000;
    sum = 17'h00000;
    trip_now = 1'b0;
    peak_raw = 16'h0000;
    peak_max = 16'h0000;

    // Three-stage synchronisers on the pins
    next_r.sync_open = {r.sync_open[1:0], timer_pin_open};
    next_r.sync_gnd = {r.sync_gnd[1:0], timer_pin_grounded};
    next_r.sync_ver = {r.sync_ver[1:0], latch_version_pin};
    next_r.pin_open = sync_filter(r.sync_open, r.pin_open);
    next_r.pin_gnd = sync_filter(r.sync_gnd, r.pin_gnd);
    next_r.ver_filt = sync_filter(r.sync_ver, r.ver_filt);

    // Version strap caught once the chain has filled; reset zeros would agree too early
    if (!r.strap_done) begin
      if (r.strap_wait != tlft_pkg::STRAP_SETTLE) begin
        next_r.strap_wait = r.strap_wait + 2'h1;
      end else begin
        next_r.latch_version = next_r.ver_filt; // [R06]
        next_r.strap_done = 1'b1;
      end
    end

    // Fault detection from the feedback level
    ovl_now = (feedback_level >= ovl_threshold(r.power_limit_offset)); // [R01] [R07]
    sc_now = (feedback_level > tlft_pkg::FB_OPEN_LOOP_MV); // [R02]
    next_r.overload_condition = ovl_now;
    next_r.short_circuit_condition = sc_now;

    // Peak current command follows feedback over four above light load
    peak_max = (r.power_limit_offset >= tlft_pkg::CS_LIMIT_MV) ? 16'h0000
             : (tlft_pkg::CS_LIMIT_MV - r.power_limit_offset);
    if (feedback_level < tlft_pkg::LIGHT_LOAD_FB_MV) begin
      peak_raw = 16'(tlft_pkg::LIGHT_LOAD_FB_MV >> tlft_pkg::PEAK_RATIO_SHIFT); // [R11]
    end else begin
      peak_raw = 16'(feedback_level >> tlft_pkg::PEAK_RATIO_SHIFT); // [R11]
    end
    next_r.peak_mv = (peak_raw > peak_max) ? peak_max : peak_raw; // [R11]

    // Millisecond tick divider
    if (r.tick_cnt >= TICK_LAST) begin
      next_r.tick_cnt = 16'h0000;
      tick = 1'b1;
    end else begin
      next_r.tick_cnt = r.tick_cnt + 16'h0001;
    end

    // Terminal count, with fallback for a faulty setting pin
    if (r.pin_gnd) begin
      terminal = TIMER_GND_MS; // [R09]
    end else if (r.pin_open) begin
      terminal = TIMER_OPEN_MS; // [R09]
    end else if (r.timer_set == 16'h0000) begin
      terminal = tlft_pkg::OVL_DEFAULT_MS; // [R08]
    end else begin
      terminal = r.timer_set; // [R08]
    end

    // Step size picks the rate; progress is kept across rate changes
    step = sc_now ? tlft_pkg::SC_STEP : tlft_pkg::OVL_STEP; // [R02] [R04] [R10] [R12]
    sum = {1'b0, r.count} + {1'b0, step}; // [R12]

    // Protection sequence
    case (r.mode)
      tlft_pkg::TLFT_RUN: begin
        if (!r.enable) begin
          next_r.count = 16'h0000;
        end else if (!ovl_now && !sc_now) begin
          next_r.count = 16'h0000; // [R03] [R10]
        end else if (tick) begin
          if (sum >= {1'b0, terminal}) begin
            trip_now = 1'b1; // [R12]
            next_r.count = terminal;
            next_r.tripped = 1'b1;
            next_r.hiccup_cnt = 16'h0000;
            next_r.mode = r.latch_version ? tlft_pkg::TLFT_LATCHED : tlft_pkg::TLFT_HICCUP; // [R06]
          end else begin
            next_r.count = sum[15:0]; // [R01] [R04] [R12]
          end
        end
      end
      tlft_pkg::TLFT_HICCUP: begin
        // Off time then a fresh start with the timer cleared
        if (tick) begin
          if (r.hiccup_cnt + 16'h0001 >= r.hiccup_set) begin
            next_r.mode = tlft_pkg::TLFT_RUN; // [R06]
            next_r.count = 16'h0000;
            next_r.tripped = 1'b0;
            next_r.hiccup_cnt = 16'h0000;
          end else begin
            next_r.hiccup_cnt = r.hiccup_cnt + 16'h0001;
          end
        end
      end
      tlft_pkg::TLFT_LATCHED: begin
        next_r.mode = tlft_pkg::TLFT_LATCHED; // [R06]
      end
      default: begin
        next_r.mode = tlft_pkg::TLFT_LATCHED;
      end
    endcase

    // Drive is blocked in the trip cycle and while not running
    next_r.drive = pwm_request && r.enable && (r.mode == tlft_pkg::TLFT_RUN) && !trip_now; // [R05]

    // Bus data phase: write lands at the end of the phase
    if (r.a_valid && r.a_write) begin
      case (r.a_addr)
        tlft_pkg::REG_CTRL: next_r.enable = hwdata[tlft_pkg::CTRL_ENABLE_BIT];
        tlft_pkg::REG_POWER_OFFSET: next_r.power_limit_offset = hwdata[15:0]; // [R07]
        tlft_pkg::REG_TIMER_SET: next_r.timer_set = hwdata[15:0]; // [R08]
        tlft_pkg::REG_HICCUP_SET: next_r.hiccup_set = hwdata[15:0];
        default: begin
        end
      endcase
    end

    // Read: one wait cycle, then data from the settled state
    if (r.rd_wait) begin
      next_r.rdata = read_word(r, r.a_addr);
      next_r.rd_wait = 1'b0;
      next_r.a_valid = 1'b0;
    end else begin
      next_r.a_valid = addr_take;
      next_r.a_write = addr_take && hwrite;
      next_r.a_addr = addr_take ? {haddr[7:2], 2'b00} : r.a_addr;
      next_r.rd_wait = addr_take && !hwrite;
      if (haddr[31:8] != 24'h000000) begin
        next_r.a_addr = addr_take ? 8'hFC : r.a_addr; // Out of range reads zero
      end
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r.sync_open <= 3'h0;
      r.sync_gnd <= 3'h0;
      r.sync_ver <= 3'h0;
      r.pin_open <= 1'b0;
      r.pin_gnd <= 1'b0;
      r.ver_filt <= 1'b0;
      r.latch_version <= 1'b0;
      r.strap_done <= 1'b0;
      r.strap_wait <= 2'h0;
      r.enable <= tlft_pkg::CTRL_ENABLE_RESET;
      r.power_limit_offset <= tlft_pkg::POWER_OFFSET_RESET;
      r.timer_set <= tlft_pkg::OVL_DEFAULT_MS;
      r.hiccup_set <= tlft_pkg::HICCUP_DEFAULT_MS;
      r.tick_cnt <= 16'h0000;
      r.count <= 16'h0000;
      r.hiccup_cnt <= 16'h0000;
      r.mode <= tlft_pkg::TLFT_RUN;
      r.tripped <= 1'b0;
      r.overload_condition <= 1'b0;
      r.short_circuit_condition <= 1'b0;
      r.peak_mv <= 16'h0000;
      r.drive <= 1'b0;
      r.a_valid <= 1'b0;
      r.a_write <= 1'b0;
      r.a_addr <= 8'h00;
      r.rd_wait <= 1'b0;
      r.rdata <= 32'h00000000;
    end else begin
      r <= next_r;
    end
  end

  // Outputs
  assign hrdata = r.rdata;
  assign hreadyout = !r.rd_wait; // Read stalls one cycle
  assign hresp = 1'b0; // Always OKAY
  assign gate_drive = r.drive;
  assign fault_tripped = r.tripped;
  assign peak_current_cmd = r.peak_mv;

endmodule : tlft_top

// ---- dv/tlft_partner.sv ----
// Feedback converter and PWM source model
`timescale 1ns/1ps
module tlft_partner (
  input wire logic hclk,
  input wire logic [15:0] level,
  output logic [15:0] feedback_level = 16'h03E8,
  output logic pwm_request = 1'b0
);
  logic [1:0] phase = 2'h0;
  // Converter word lags the level by one cycle
  always @(posedge hclk) begin
    feedback_level <= level;
    phase <= phase + 2'h1;
    pwm_request <= phase != 2'h3;
  end
endmodule : tlft_partner

// ---- dv/tlft_assertions.sv ----
// Port checker of the fault timer
`timescale 1ns/1ps
module tlft_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [15:0] feedback_level,
  input wire logic pwm_request,
  input wire logic gate_drive,
  input wire logic fault_tripped,
  input wire logic [15:0] peak_current_cmd
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Bus read steps
  sequence rd_take; hsel && htrans[1] && hready && !hwrite; endsequence
  sequence rd_stall; !hreadyout ##1 hreadyout; endsequence
  read_wait_a: assert property (rd_take |=> rd_stall) else $error("read wait wrong");
  write_ready_a: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout) else $error("write stalled");
  resp_okay_a: assert property (hresp == 1'b0) else $error("error response");
  trip_stop_a: assert property (fault_tripped |-> !gate_drive) else $error("drive while tripped");
  drive_cause_a: assert property (gate_drive |-> $past(pwm_request)) else $error("drive without request");
  peak_max_a: assert property (peak_current_cmd <= 16'h0320) else $error("peak above limit");
  peak_light_a: assert property ($past(feedback_level) < 16'h03E8 |-> peak_current_cmd <= 16'h00FA)
    else $error("light load peak wrong");
  peak_ratio_a: assert property ($past(feedback_level) >= 16'h03E8 |-> peak_current_cmd <= ($past(feedback_level) >> 2))
    else $error("peak above ratio");
endmodule : tlft_checker

// ---- dv/test_two_level_fault_timer.sv ----
// Self-checking bench of the fault timer
`timescale 1ns/1ps
module test_two_level_fault_timer;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [15:0] level = 16'h03E8;
  logic [15:0] feedback_level;
  logic pwm_request;
  logic pin_open = 1'b0;
  logic pin_gnd = 1'b0;
  logic latch_pin = 1'b0;
  logic gate_drive;
  logic fault_tripped;
  logic [15:0] peak_current_cmd;
  logic rd = 1'b0;
  logic [31:0] notes[$];
  logic [31:0] ta[5] = '{32'h08, 32'h0C, 32'h04, 32'h10, 32'h1C};
  logic [31:0] td[5] = '{32'h14, 32'h08, 32'hC8, 32'hFF, 32'h55};
  logic [31:0] te[5] = '{32'h14, 32'h08, 32'hC8, 32'h00, 32'h00};
  int err_total = 0;
  int samples_checked = 0;
  int seed = 91933;
  logic [15:0] fb;
  tlft_top #(.TICK_CYCLES(4), .TIMER_OPEN_MS(16'h000C), .TIMER_GND_MS(16'h0008)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .feedback_level(feedback_level), .pwm_request(pwm_request),
    .timer_pin_open(pin_open), .timer_pin_grounded(pin_gnd), .latch_version_pin(latch_pin),
    .gate_drive(gate_drive), .fault_tripped(fault_tripped), .peak_current_cmd(peak_current_cmd));
  tlft_partner far (.hclk(hclk), .level(level), .feedback_level(feedback_level), .pwm_request(pwm_request));
  // Clock
  initial forever #50 hclk = ~hclk;
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("BAD %s expected %h seen %h", name, exp, seen);
      err_total++;
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc
  // One AHB single transfer; reads note their expectation
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    rd <= !w;
    if (!w) notes.push_back(d);
    do @(negedge hclk); while (hreadyout !== 1'b1);
    @(posedge hclk);
    rd <= 1'b0;
  endtask : xfer
  // Fault sequence: optional first level, second level, trip window, recovery
  task automatic fault(input logic [15:0] a, input int na, input logic [15:0] b, input int lo, input int hi,
    input logic lat);
    if (na > 0) begin
      level <= a;
      cyc(na);
    end
    level <= b;
    cyc(lo);
    @(negedge hclk);
    chk("early trip", 32'(fault_tripped), 32'h0);
    cyc(hi - lo);
    @(negedge hclk);
    chk("trip", 32'(fault_tripped), 32'h1);
    level <= 16'h03E8;
    cyc(48);
    @(negedge hclk);
    chk("recovery", 32'(fault_tripped), 32'(lat));
  endtask : fault
  task automatic summarize;
    if (err_total == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  // Read data against the oldest note
  always @(negedge hclk) begin
    if (rd && hreadyout === 1'b1 && notes.size() > 0) chk("hrdata", hrdata, notes.pop_front());
  end
  // Watchdog
  initial begin
    cyc(20000);
    err_total++;
    summarize();
  end
  // Main sequence
  initial begin
    cyc(6);
    hresetn <= 1'b1;
    cyc(2);
    xfer(1'b0, 32'h00, 32'h1);
    xfer(1'b0, 32'h08, 32'h1F4);
    xfer(1'b0, 32'h0C, 32'h3E8);
    xfer(1'b0, 32'h100, 32'h0);
    for (int i = 0; i < 5; i++) xfer(1'b1, ta[i], td[i]);
    for (int i = 0; i < 5; i++) xfer(1'b0, ta[i], te[i]);
    for (int i = 0; i < 7; i++) begin
      fb = (i == 6) ? 16'h0AF0 : 16'((($random(seed)) & 32'h7FFF) % 2400);
      level <= fb;
      cyc(3);
      xfer(1'b0, 32'h18, fb < 16'h03E8 ? 32'hFA : (fb > 16'h0960 ? 32'h258 : 32'(fb >> 2)));
    end
    fault(16'h095F, 100, 16'h0960, 75, 82, 1'b0);
    level <= 16'h0960;
    cyc(60);
    fault(16'h03E8, 2, 16'h0960, 75, 82, 1'b0);
    fault(16'h1068, 0, 16'h1068, 15, 22, 1'b0);
    fault(16'h1068, 12, 16'h0960, 28, 34, 1'b0);
    for (int i = 0; i < 2; i++) begin
      pin_gnd <= (i == 0);
      pin_open <= (i == 1);
      cyc(8);
      fault(16'h1068, 0, 16'h1068, 4 + 4 * i, 10 + 4 * i, 1'b0);
    end
    xfer(1'b0, 32'h14, 32'h0);
    hresetn <= 1'b0;
    latch_pin <= 1'b1;
    cyc(6);
    hresetn <= 1'b1;
    cyc(8);
    xfer(1'b1, 32'h0C, 32'h08);
    fault(16'h1068, 0, 16'h1068, 8, 14, 1'b1);
    summarize();
  end
endmodule : test_two_level_fault_timer
bind tlft_top tlft_checker chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .feedback_level(feedback_level),
  .pwm_request(pwm_request), .gate_drive(gate_drive), .fault_tripped(fault_tripped),
  .peak_current_cmd(peak_current_cmd));
